// ### shared/rtf_consts.svh
// Offsets, field positions, reset values and timing counts of the table-fetch block.
// Assumes a Wishbone slave decoding word addresses (byte address = 4 * index).
`ifndef RTF_CONSTS_SVH
`define RTF_CONSTS_SVH

// ****************************************
// Register indices
// ****************************************
`define RTF_IDX_HIGH_BYTE 8'h82
`define RTF_IDX_LOW_INDEX 8'h83
`define RTF_IDX_MID_INDEX 8'h84
`define RTF_IDX_TOP_ADDR 8'h85
`define RTF_IDX_BANK 8'h87
`define RTF_IDX_ACC 8'hF0
`define RTF_IDX_CMD 8'hF1
`define RTF_IDX_STATUS 8'hF2
`define RTF_IDX_PC_LOW 8'hCE
`define RTF_IDX_PC_HIGH 8'hCF

// ****************************************
// Fields and reset values
// ****************************************
`define RTF_BANK_LSB 0
`define RTF_BANK_W 4
`define RTF_BANK_RST 4'h0
`define RTF_BANK_MAX 4'h8
`define RTF_BANK_LCD 4'hF
`define RTF_CMD_FETCH 0
`define RTF_CMD_ADD_PCL 1
`define RTF_CMD_ADC_PCL 2
`define RTF_ST_BUSY 0
`define RTF_ST_CARRY 1
`define RTF_ST_BANK_OK 2
`define RTF_ST_LCD 3
`define RTF_JMP_WORDS 2
`define RTF_PAGE_HAZ_A 8'hFD
`define RTF_PAGE_HAZ_B 8'hFE

// ****************************************
// Timing
// ****************************************
`define RTF_ROM_LAT_CYC 1

`endif

// ### shared/rtf_pkg.sv
// Types shared by the table-fetch block.
// Assumes the constants header is included by the design files.
package rtf_pkg;
    typedef enum logic [1:0] {
        RTF_IDLE = 2'b00,
        RTF_READ = 2'b01,
        RTF_DONE = 2'b10
    } rtf_state_t;
endpackage : rtf_pkg

// ### rtl/rtf_rom.sv
// Program-memory model: 16-bit words, registered read data.
// Assumes the loader writes words before the core fetches them.
module rtf_rom #(
    parameter int AW = 24,
    parameter int DEPTH = 1024
) (
    input wire logic clk,
    input wire logic [AW-1:0] rd_addr,
    output logic [15:0] rd_data,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [15:0] wr_data
);
    localparam int IW = $clog2(DEPTH);
    logic [15:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr[IW-1:0]] <= wr_data;
        end
    end

    // Full 16-bit word on every read
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr[IW-1:0]];
    end
endmodule : rtf_rom

// ### rtl/rtf_clkdiv.sv
// Instruction-cycle divider: one tick every DIV oscillator clocks.
// Assumes DIV is one of 1, 2, 4, 8, 16 chosen at build time.
module rtf_clkdiv #(
    parameter int DIV = 1
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    logic [4:0] cnt_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 5'h00;
            tick <= 1'b0;
        end else if (cnt_r == 5'(DIV - 1)) begin
            cnt_r <= 5'h00;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 5'h01;
            tick <= 1'b0;
        end
    end

    a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
        tick && DIV > 1 |=> !tick) else $error("tick too frequent");
endmodule : rtf_clkdiv

// ### rtl/rtf_core.sv
// Table fetch, jump-table dispatch and RAM bank select, behind a Wishbone slave.
// Assumes a classic Wishbone master on the clk domain; 32-bit data, word registers.
//
// Operation
// - Fetch address is top, middle and low index bytes, high to low.
// - Fetched low byte goes to accumulator, high byte to fetched_high_byte.
// - Index bytes never carry into each other on wrap.
// - Each fetched program word is sixteen bits.
// - Adding accumulator to pc_low_byte loads the sum as new low PC.
// - Instruction cycle is 1, 2, 4, 8 or 16 oscillator clocks.
// - Four-bit bank field, read-write, reset zero, codes 0-8 select banks.
// - Bank code 1111 selects bank 15, the display segment RAM.
// - Jump and call take two words, so jump entries are two apart.
`include "rtf_consts.svh"
module rtf_core
    import rtf_pkg::*;
#(
    parameter int CYC_DIV = 1,
    parameter int ROM_DEPTH = 1024
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rom_wr_en,
    input wire logic [23:0] rom_wr_addr,
    input wire logic [15:0] rom_wr_data,
    output logic [3:0] ram_bank_select_o,
    output logic lcd_bank_sel_o,
    output logic [15:0] pc_o
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] fetched_high_byte_r;
    logic [7:0] table_low_index_r;
    logic [7:0] table_mid_index_r;
    logic [7:0] table_top_addr_r;
    logic [7:0] acc_r;
    logic [7:0] pc_low_byte_r;
    logic [7:0] pc_high_byte_r;
    logic [3:0] bank_r;
    logic carry_r;
    rtf_state_t state_r;
    logic [15:0] rom_q;
    logic tick;
    logic [7:0] idx;
    logic req;
    logic wr;
    logic lane0;
    logic [8:0] pcl_sum;

    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && lane0;
    assign lane0 = wb_sel_i[0];

    rtf_clkdiv #(.DIV(CYC_DIV)) u_div (
        .clk(clk),
        .rst(rst),
        .tick(tick)
    );

    rtf_rom #(.AW(24), .DEPTH(ROM_DEPTH)) u_rom (
        .clk(clk),
        .rd_addr({table_top_addr_r, table_mid_index_r, table_low_index_r}),
        .rd_data(rom_q),
        .wr_en(rom_wr_en),
        .wr_addr(rom_wr_addr),
        .wr_data(rom_wr_data)
    );

    // ****************************************
    // Wishbone ack and read data
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            case (idx)
                `RTF_IDX_HIGH_BYTE: wb_dat_o <= {24'h0, fetched_high_byte_r};
                `RTF_IDX_LOW_INDEX: wb_dat_o <= {24'h0, table_low_index_r};
                `RTF_IDX_MID_INDEX: wb_dat_o <= {24'h0, table_mid_index_r};
                `RTF_IDX_TOP_ADDR: wb_dat_o <= {24'h0, table_top_addr_r};
                `RTF_IDX_BANK: wb_dat_o <= {28'h0, bank_r};
                `RTF_IDX_ACC: wb_dat_o <= {24'h0, acc_r};
                `RTF_IDX_PC_LOW: wb_dat_o <= {24'h0, pc_low_byte_r};
                `RTF_IDX_PC_HIGH: wb_dat_o <= {24'h0, pc_high_byte_r};
                `RTF_IDX_STATUS: begin
                    wb_dat_o <= {28'h0, bank_r == `RTF_BANK_LCD,
                        bank_r <= `RTF_BANK_MAX || bank_r == `RTF_BANK_LCD,
                        carry_r, state_r != RTF_IDLE};
                end
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Fetch sequencer
    // ****************************************
    logic fetch_go;
    logic add_go;
    assign fetch_go = wr && idx == `RTF_IDX_CMD && wb_dat_i[`RTF_CMD_FETCH];
    assign add_go = wr && idx == `RTF_IDX_CMD
        && (wb_dat_i[`RTF_CMD_ADD_PCL] || wb_dat_i[`RTF_CMD_ADC_PCL]);
    assign pcl_sum = {1'b0, pc_low_byte_r} + {1'b0, acc_r}
        + {8'h00, wb_dat_i[`RTF_CMD_ADC_PCL] & carry_r};

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= RTF_IDLE;
        end else begin
            case (state_r)
                RTF_IDLE: if (fetch_go) state_r <= RTF_READ;
                RTF_READ: if (tick) state_r <= RTF_DONE;
                RTF_DONE: state_r <= RTF_IDLE;
                default: state_r <= RTF_IDLE;
            endcase
        end
    end

    // Index bytes: written only by software, no carry between them
    always_ff @(posedge clk) begin
        if (rst) begin
            table_low_index_r <= 8'h00;
            table_mid_index_r <= 8'h00;
            table_top_addr_r <= 8'h00;
        end else if (wr) begin
            if (idx == `RTF_IDX_LOW_INDEX) table_low_index_r <= wb_dat_i[7:0];
            if (idx == `RTF_IDX_MID_INDEX) table_mid_index_r <= wb_dat_i[7:0];
            if (idx == `RTF_IDX_TOP_ADDR) table_top_addr_r <= wb_dat_i[7:0];
        end
    end

    // Fetch result beats a same-cycle software write
    always_ff @(posedge clk) begin
        if (rst) begin
            fetched_high_byte_r <= 8'h00;
            acc_r <= 8'h00;
        end else if (state_r == RTF_DONE) begin
            acc_r <= rom_q[7:0];
            fetched_high_byte_r <= rom_q[15:8];
        end else if (wr) begin
            if (idx == `RTF_IDX_ACC) acc_r <= wb_dat_i[7:0];
            if (idx == `RTF_IDX_HIGH_BYTE) fetched_high_byte_r <= wb_dat_i[7:0];
        end
    end

    // ****************************************
    // Program counter and jump table
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_low_byte_r <= 8'h00;
            pc_high_byte_r <= 8'h00;
            carry_r <= 1'b0;
        end else if (add_go) begin
            pc_low_byte_r <= pcl_sum[7:0];
            carry_r <= pcl_sum[8];
        end else if (wr && idx == `RTF_IDX_PC_LOW) begin
            pc_low_byte_r <= wb_dat_i[7:0];
        end else if (wr && idx == `RTF_IDX_PC_HIGH) begin
            pc_high_byte_r <= wb_dat_i[7:0];
        end else if (tick && state_r == RTF_IDLE) begin
            // Jump entries step by two words
            {pc_high_byte_r, pc_low_byte_r} <=
                {pc_high_byte_r, pc_low_byte_r} + 16'(`RTF_JMP_WORDS);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bank_r <= `RTF_BANK_RST;
        end else if (wr && idx == `RTF_IDX_BANK) begin
            bank_r <= wb_dat_i[`RTF_BANK_W-1:0];
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ram_bank_select_o <= 4'h0;
            lcd_bank_sel_o <= 1'b0;
            pc_o <= 16'h0000;
        end else begin
            ram_bank_select_o <= bank_r;
            lcd_bank_sel_o <= bank_r == `RTF_BANK_LCD;
            pc_o <= {pc_high_byte_r, pc_low_byte_r};
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_fetch_split: assert property (@(posedge clk) disable iff (rst)
        state_r == RTF_DONE |=> acc_r == $past(rom_q[7:0])
        && fetched_high_byte_r == $past(rom_q[15:8])) else $error("fetch split");
    a_no_carry: assert property (@(posedge clk) disable iff (rst)
        wr && idx == `RTF_IDX_LOW_INDEX |=> $stable(table_mid_index_r))
        else $error("index carry");
    a_pcl_load: assert property (@(posedge clk) disable iff (rst)
        add_go && !wb_dat_i[`RTF_CMD_ADC_PCL]
        |=> pc_low_byte_r == 8'($past(pc_low_byte_r) + $past(acc_r)))
        else $error("pcl add");
    a_bank_reset: assert property (@(posedge clk)
        rst |=> bank_r == 4'h0) else $error("bank reset");
    a_lcd_bank: assert property (@(posedge clk) disable iff (rst)
        bank_r == 4'hF |=> lcd_bank_sel_o) else $error("lcd bank");
    a_fetch_addr: assert property (@(posedge clk) disable iff (rst)
        state_r == RTF_READ |-> $stable(table_low_index_r) || !$past(wr))
        else $error("fetch addr");
    a_top_hold: assert property (@(posedge clk) disable iff (rst)
        !(wr && idx == `RTF_IDX_TOP_ADDR) |=> $stable(table_top_addr_r))
        else $error("top byte changed");
    // Idle instruction tick steps the program counter by one jump entry
    a_pc_step: assert property (@(posedge clk) disable iff (rst)
        tick && state_r == RTF_IDLE && !wr && !add_go
        |=> {pc_high_byte_r, pc_low_byte_r} == 16'($past({pc_high_byte_r, pc_low_byte_r})
        + 16'h0002)) else $error("pc step");
    a_fetch_len: assert property (@(posedge clk) disable iff (rst)
        fetch_go && state_r == RTF_IDLE |-> ##[1:17] state_r == RTF_DONE)
        else $error("fetch slow");
    c_fetch: cover property (@(posedge clk) state_r == RTF_DONE);
    c_add: cover property (@(posedge clk) add_go);
    c_lcd: cover property (@(posedge clk) lcd_bank_sel_o);
    c_adc_carry: cover property (@(posedge clk) add_go && wb_dat_i[`RTF_CMD_ADC_PCL] && carry_r);
    c_bank_odd: cover property (@(posedge clk) bank_r > `RTF_BANK_MAX && bank_r != `RTF_BANK_LCD);
endmodule : rtf_core

// ### verif/rtf_rom_loader.sv
// Program-memory loader: writes three table words after reset.
// Assumes the core takes one preload word per clock on rom_wr_*.
module rtf_rom_loader (
    input wire logic clk,
    input wire logic rst,
    output logic rom_wr_en,
    output logic [23:0] rom_wr_addr,
    output logic [15:0] rom_wr_data,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [39:0] IMG [3] = '{40'h0002FF_5105, 40'h000200_2012, 40'h000300_0035};
    int n = 0;
    always @(posedge clk) begin
        if (rst) begin
            rom_wr_en <= 1'b0;
            {rom_wr_addr, rom_wr_data} <= 40'h0;
            done <= 1'b0;
            n <= 0;
        end else begin
            rom_wr_en <= n < 3;
            done <= n >= 3;
            if (n < 3) begin
                {rom_wr_addr, rom_wr_data} <= IMG[n];
                n <= n + 1;
            end
        end
    end
endmodule : rtf_rom_loader

// ### verif/tb_top.sv
// Bench for the table-fetch core: registers, bank, fetch, jump and divider.
// Assumes the loader fills program memory long before the first fetch.
`include "rtf_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = 16;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dw = 32'h0;
    logic [31:0] dr;
    logic [31:0] rd;
    logic ack;
    logic lcd;
    logic ren;
    logic [23:0] ra;
    logic [15:0] rdat;
    logic [3:0] bank;
    logic [15:0] pc;
    logic [15:0] pc0;
    logic [7:0] d;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    logic [7:0] regs [4] = '{`RTF_IDX_HIGH_BYTE, `RTF_IDX_LOW_INDEX, `RTF_IDX_MID_INDEX,
        `RTF_IDX_TOP_ADDR};

    always #5 clk = ~clk;

    rtf_rom_loader ldr (.clk(clk), .rst(rst), .rom_wr_en(ren), .rom_wr_addr(ra),
        .rom_wr_data(rdat), .done());
    rtf_core #(.CYC_DIV(DIV)) dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .rom_wr_en(ren), .rom_wr_addr(ra), .rom_wr_data(rdat),
        .ram_bank_select_o(bank), .lcd_bank_sel_o(lcd), .pc_o(pc));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] v,
        input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        dw <= v;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        wb(1'b1, idx, v, 4'hF);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] e);
        wb(1'b0, idx, 32'h0, 4'hF);
        chk(nm, e, rd);
    endtask : rdc

    task automatic fetch(input logic [15:0] w);
        wr(`RTF_IDX_CMD, 32'h1 << `RTF_CMD_FETCH);
        do begin
            wb(1'b0, `RTF_IDX_STATUS, 32'h0, 4'hF);
        end while (rd[`RTF_ST_BUSY] !== 1'b0);
        rdc("acc", `RTF_IDX_ACC, {24'h0, w[7:0]});
        rdc("high_byte", `RTF_IDX_HIGH_BYTE, {24'h0, w[15:8]});
    endtask : fetch

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("bank_out", 32'h0, {28'h0, bank});
        rdc("bank", `RTF_IDX_BANK, 32'h0);
        $display("test reset finished");
        foreach (regs[i]) begin
            wr(regs[i], {24'hABCDEF, 8'hA5 ^ 8'(i)});
            rdc("index_reg", regs[i], {24'h0, 8'hA5 ^ 8'(i)});
        end
        wb(1'b1, `RTF_IDX_LOW_INDEX, 32'h11, 4'hE);
        rdc("lane_off", `RTF_IDX_LOW_INDEX, 32'hA4);
        wr(8'h10, 32'h77);
        rdc("unmapped", 8'h10, 32'h0);
        $display("test registers finished");
        for (int i = 0; i < 16; i++) begin
            wr(`RTF_IDX_BANK, 32'(i));
            rdc("bank", `RTF_IDX_BANK, 32'(i));
            chk("bank_out", 32'(i), {28'h0, bank});
            chk("lcd_sel", 32'(i == 15), {31'h0, lcd});
            wb(1'b0, `RTF_IDX_STATUS, 32'h0, 4'hF);
            chk("bank_code", 32'(i <= 8 || i == 15), {31'h0, rd[`RTF_ST_BANK_OK]});
            chk("lcd_code", 32'(i == 15), {31'h0, rd[`RTF_ST_LCD]});
        end
        $display("test bank finished");
        wr(`RTF_IDX_TOP_ADDR, 32'h0);
        wr(`RTF_IDX_MID_INDEX, 32'h2);
        wr(`RTF_IDX_LOW_INDEX, 32'hFF);
        fetch(16'h5105);
        // Low byte wraps by software, middle byte stays
        wr(`RTF_IDX_LOW_INDEX, 32'h0);
        rdc("mid_index", `RTF_IDX_MID_INDEX, 32'h2);
        fetch(16'h2012);
        wr(`RTF_IDX_MID_INDEX, 32'h3);
        fetch(16'h0035);
        $display("test fetch finished");
        for (int k = 1; k <= 2; k++) begin
            wr(`RTF_IDX_ACC, 32'h6);
            // First add carries out of the low byte, second adds that carry back in
            wr(`RTF_IDX_PC_LOW, (k == 1) ? 32'hFA : 32'h10);
            wr(`RTF_IDX_PC_HIGH, 32'h1);
            wr(`RTF_IDX_CMD, 32'h1 << k);
            d = pc[7:0] - ((k == 1) ? 8'h00 : 8'h17);
            chk("pc_jump", 32'h1, 32'(pc[15:8] === 8'h01 && d inside {8'h0, 8'h2, 8'h4}));
            wb(1'b0, `RTF_IDX_STATUS, 32'h0, 4'hF);
            chk("carry", 32'(k == 1), {31'h0, rd[`RTF_ST_CARRY]});
        end
        $display("test jump finished");
        repeat (2) begin
            pc0 = pc;
            n = 0;
            while (pc === pc0 && n < 40) begin
                @(posedge clk);
                n++;
            end
        end
        chk("tick_len", DIV, n);
        chk("pc_step", {16'h0, pc0 + 16'h2}, {16'h0, pc});
        $display("test divider finished");
        end_of_test();
    end
endmodule : tb_top
